// ### rtl/iqe_pkg.sv
// package for the io agent feature-enable block: addresses, fields, reset values
// assumes a single processor clock and synchronous active-high reset
package iqe_pkg;

    // model-specific address of the feature-enable register
    localparam logic [31:0] FEAT_ADDR        = 32'h0000_0c83;
    // identification query leaves and sub-leaves
    localparam logic [31:0] LEAF_MONITOR     = 32'h0000_000f;
    localparam logic [31:0] LEAF_ALLOC       = 32'h0000_0010;
    localparam logic [31:0] SUBLEAF_L3       = 32'h0000_0001;
    localparam logic [31:0] SUBLEAF_L2       = 32'h0000_0002;
    // bit positions in query results
    localparam int          BIT_OCC_MON      = 9;
    localparam int          BIT_BW_MON       = 10;
    localparam int          BIT_IO_ALLOC     = 1;
    localparam int          BIT_CDP          = 2;
    // bit positions in the feature-enable register
    localparam int          BIT_ALLOC_EN     = 0;
    localparam int          BIT_MON_EN       = 1;
    localparam int          FEAT_DEF_BITS    = 2;
    localparam logic [63:0] FEAT_RESET       = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FEAT_RSVD_MASK   = 64'hffff_ffff_ffff_fffc;

    // platform capability straps
    typedef struct packed {
        logic occ_mon;       // processor-agent occupancy monitor present
        logic bw_mon;        // processor-agent bandwidth monitor present
        logic alloc;         // processor-agent cache allocation present
        logic code_data_split_priority;           // code/data split priority present
        logic io_occ_mon;    // non-processor occupancy monitor present
        logic io_bw_mon;     // non-processor bandwidth monitor present
        logic io_alloc;      // non-processor cache allocation present
    } iqe_caps_s;

    // register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [63:0] wdata;
    } iqe_req_s;

    // register access answer
    typedef struct packed {
        logic        valid;
        logic        fault;
        logic [63:0] rdata;
    } iqe_rsp_s;

    // identification query answer
    typedef struct packed {
        logic        valid;
        logic [31:0] res_a;
        logic [31:0] res_c;
    } iqe_id_rsp_s;

endpackage

// ### rtl/iqe_id_query.sv
// identification query decode for the non-processor agent capability bits
// assumes leaf/sub-leaf requests arrive as one-cycle strobes on ref_clk
`timescale 1ns/10ps
module iqe_id_query
(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire iqe_pkg::iqe_caps_s caps,
    input  wire logic              id_valid,
    input  wire logic [31:0]       id_leaf,
    input  wire logic [31:0]       id_subleaf,
    output iqe_pkg::iqe_id_rsp_s   id_rsp
);

    iqe_pkg::iqe_id_rsp_s rsp_reg;
    iqe_pkg::iqe_id_rsp_s rsp_next;

    always_comb
    begin
        rsp_next       = '0;
        rsp_next.valid = id_valid;
        if (id_valid && id_leaf == iqe_pkg::LEAF_MONITOR && id_subleaf == iqe_pkg::SUBLEAF_L3)
        begin
            rsp_next.res_a[iqe_pkg::BIT_OCC_MON] = caps.io_occ_mon;
            rsp_next.res_a[iqe_pkg::BIT_BW_MON]  = caps.io_bw_mon;
        end
        if (id_valid && id_leaf == iqe_pkg::LEAF_ALLOC && id_subleaf == iqe_pkg::SUBLEAF_L3)
        begin
            rsp_next.res_c[iqe_pkg::BIT_IO_ALLOC] = caps.io_alloc;
            rsp_next.res_c[iqe_pkg::BIT_CDP]      = caps.code_data_split_priority;
        end
        // second-level sub-leaf gets no agent bits, stays zero
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rsp_reg <= '0;
        else
            rsp_reg <= rsp_next;
    end

    assign id_rsp = rsp_reg;

    a_id_l2_clear: assert property (@(posedge ref_clk) disable iff (srst)
        id_valid && id_leaf == iqe_pkg::LEAF_ALLOC && id_subleaf == iqe_pkg::SUBLEAF_L2
        |=> id_rsp.valid && id_rsp.res_c == 32'h0000_0000)
        else $error("second-level sub-leaf reported agent bits");

    a_id_occ_bit: assert property (@(posedge ref_clk) disable iff (srst)
        id_valid && id_leaf == iqe_pkg::LEAF_MONITOR && id_subleaf == iqe_pkg::SUBLEAF_L3
        |=> id_rsp.res_a[iqe_pkg::BIT_OCC_MON] == $past(caps.io_occ_mon)
            && id_rsp.res_a[iqe_pkg::BIT_BW_MON] == $past(caps.io_bw_mon))
        else $error("monitor capability bits wrong");

    a_id_alloc_bit: assert property (@(posedge ref_clk) disable iff (srst)
        id_valid && id_leaf == iqe_pkg::LEAF_ALLOC && id_subleaf == iqe_pkg::SUBLEAF_L3
        |=> id_rsp.res_c[iqe_pkg::BIT_IO_ALLOC] == $past(caps.io_alloc)
            && id_rsp.res_c[iqe_pkg::BIT_CDP] == $past(caps.code_data_split_priority))
        else $error("allocation capability bits wrong");

endmodule

// ### rtl/iqe_feature_enable.sv
// feature-enable register for non-processor agent cache/bandwidth qos, one per l3
// assumes privileged register accesses arrive as one-cycle strobes on ref_clk
`timescale 1ns/10ps

// How it works
// - monitor leaf sub-leaf one reports occupancy monitor capability in bit 9.
// - same sub-leaf reports bandwidth monitor capability in bit 10.
// - allocation leaf sub-leaf one reports agent allocation capability in bit 1.
// - allocation sub-leaf bit 2 still reports code/data split support.
// - second-level allocation sub-leaf reports no agent capability bits.
// - enable register exists whenever any agent capability bit is set.
// - enable bit 0 activates agent allocation features.
// - enable bit 1 activates agent monitoring features.
// - monitoring enable only supported when an agent monitor capability exists.
// - allocation enable only supported when an agent allocation capability exists.
// - register resets to zero; both feature classes start disabled.
// - writing nonzero into bits 63 to 2 faults with code zero.
// - enabling a feature without its processor-agent base feature faults.
// - memory-mapped enables of unsupported features are silently ignored.
// - agent features obey existing tag count limits per cache level.
// - one register per l3; software programs all with one value.
module iqe_feature_enable
#(
    parameter int MON_TAG_MAX   = 256,
    parameter int CLASS_TAG_MAX = 16
)
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire iqe_pkg::iqe_caps_s caps,
    input  wire iqe_pkg::iqe_req_s  req,
    output iqe_pkg::iqe_rsp_s       rsp,
    input  wire logic               id_valid,
    input  wire logic [31:0]        id_leaf,
    input  wire logic [31:0]        id_subleaf,
    output iqe_pkg::iqe_id_rsp_s    id_rsp,
    input  wire logic               cfg_valid,
    input  wire logic               cfg_is_alloc,
    input  wire logic [15:0]        cfg_tag,
    output logic                    cfg_accept,
    output logic                    alloc_active,
    output logic                    monitor_active
);

    // tags are 16 bits wide and compares 17, so limits above 65536 would accept no further tag
    if (MON_TAG_MAX < 1 || MON_TAG_MAX > 65536 || CLASS_TAG_MAX < 1 || CLASS_TAG_MAX > 65536)
    begin : g_bad_limits
        $error("tag limits out of range");
    end

    localparam logic [16:0] MON_LIM   = 17'(MON_TAG_MAX);
    localparam logic [16:0] CLASS_LIM = 17'(CLASS_TAG_MAX);

    logic [1:0]        feat_reg;
    logic [1:0]        feat_next;
    iqe_pkg::iqe_rsp_s rsp_reg;
    iqe_pkg::iqe_rsp_s rsp_next;
    logic              cfg_accept_reg;
    logic              cfg_accept_next;
    logic              reg_present;
    logic              mon_ok;
    logic              alloc_ok;
    logic              hit;
    logic              fault;

    // register decodes only if some agent capability exists
    assign reg_present = caps.io_occ_mon | caps.io_bw_mon | caps.io_alloc;
    // monitoring enable needs agent monitor plus base feature
    // base processor-agent feature is a prerequisite
    assign mon_ok   = ((caps.io_occ_mon & caps.occ_mon) | (caps.io_bw_mon & caps.bw_mon));
    // allocation enable needs agent allocation plus base feature
    assign alloc_ok = caps.io_alloc & caps.alloc;
    // full address compare: neighbouring addresses fault instead of aliasing
    assign hit      = req.valid && req.addr == iqe_pkg::FEAT_ADDR;

    always_comb
    begin
        fault = 1'b0;
        if (req.valid)
        begin
            if (!hit || !reg_present)
                fault = 1'b1;
            else if (req.write)
            begin
                if ((req.wdata & iqe_pkg::FEAT_RSVD_MASK) != 64'h0000_0000_0000_0000)
                    fault = 1'b1;
                // enabling a feature whose base is absent faults
                else if (req.wdata[iqe_pkg::BIT_MON_EN] && !mon_ok)
                    fault = 1'b1;
                else if (req.wdata[iqe_pkg::BIT_ALLOC_EN] && !alloc_ok)
                    fault = 1'b1;
            end
        end
    end

    // any fault leaves the enables untouched, so a bad write is harmless
    always_comb
    begin
        feat_next = feat_reg;
        if (req.valid && req.write && !fault)
            feat_next = req.wdata[iqe_pkg::FEAT_DEF_BITS-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            feat_reg <= iqe_pkg::FEAT_RESET[iqe_pkg::FEAT_DEF_BITS-1:0];
        else
            feat_reg <= feat_next;
    end

    always_comb
    begin
        rsp_next       = '0;
        rsp_next.valid = req.valid;
        rsp_next.fault = fault;
        // a faulted read answers zero, never stale enables
        // read returns enables, reserved zero
        if (req.valid && !req.write && !fault)
            rsp_next.rdata = {62'h0, feat_reg};
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rsp_reg <= '0;
        else
            rsp_reg <= rsp_next;
    end

    // memory-mapped configuration gate, accepted only when the class is enabled
    always_comb
    begin
        cfg_accept_next = 1'b0;
        if (cfg_valid)
        begin
            // unsupported or disabled feature config silently dropped
            // tags beyond the reported limits are dropped too
            if (cfg_is_alloc)
                cfg_accept_next = feat_reg[iqe_pkg::BIT_ALLOC_EN] && ({1'b0, cfg_tag} < CLASS_LIM);
            else
                cfg_accept_next = feat_reg[iqe_pkg::BIT_MON_EN] && ({1'b0, cfg_tag} < MON_LIM);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cfg_accept_reg <= 1'b0;
        else
            cfg_accept_reg <= cfg_accept_next;
    end

    // one instance per l3; software keeps copies equal
    assign rsp            = rsp_reg;
    assign cfg_accept     = cfg_accept_reg;
    assign alloc_active   = feat_reg[iqe_pkg::BIT_ALLOC_EN];
    assign monitor_active = feat_reg[iqe_pkg::BIT_MON_EN];

    iqe_id_query u_id_query
    (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .caps       (caps),
        .id_valid   (id_valid),
        .id_leaf    (id_leaf),
        .id_subleaf (id_subleaf),
        .id_rsp     (id_rsp)
    );

    // register bus checks
    a_rsvd_fault: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && hit
        && (req.wdata & iqe_pkg::FEAT_RSVD_MASK) != 64'h0000_0000_0000_0000
        |=> rsp.valid && rsp.fault && $stable(feat_reg))
        else $error("reserved write not faulted");

    a_reset_clear: assert property (@(posedge ref_clk)
        srst |=> !alloc_active && !monitor_active && !rsp.valid)
        else $error("enables not cleared by reset");

    a_mon_support: assert property (@(posedge ref_clk) disable iff (srst)
        !mon_ok |-> ##1 !$rose(monitor_active))
        else $error("monitor enabled without capability");

    a_alloc_support: assert property (@(posedge ref_clk) disable iff (srst)
        !alloc_ok |-> ##1 !$rose(alloc_active))
        else $error("allocation enabled without capability");

    a_write_takes: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && !fault
        |=> alloc_active == $past(req.wdata[0]) && monitor_active == $past(req.wdata[1]))
        else $error("accepted write not applied");

    a_read_back: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && !req.write && hit && reg_present
        |=> !rsp.fault && rsp.rdata == {62'h0, monitor_active, alloc_active})
        else $error("read value wrong");

    a_absent_reg: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && !reg_present |=> rsp.fault)
        else $error("access to absent register not faulted");

    a_fault_keeps: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && fault
        |=> rsp.valid && rsp.fault && $stable(feat_reg))
        else $error("faulted write changed the enables");

    a_mon_base: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && hit && req.wdata[iqe_pkg::BIT_MON_EN] && !mon_ok
        |=> rsp.valid && rsp.fault)
        else $error("monitor enable without capability not faulted");

    a_alloc_base: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && hit && req.wdata[iqe_pkg::BIT_ALLOC_EN] && !alloc_ok
        |=> rsp.valid && rsp.fault)
        else $error("allocation enable without capability not faulted");

    a_addr_miss: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && !hit |=> rsp.valid && rsp.fault)
        else $error("access to other address not faulted");

    a_rsp_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        !req.valid |=> !rsp.valid)
        else $error("answer without request");

    a_rsp_answer: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid |=> rsp.valid)
        else $error("request left without answer");

    a_rdata_rsvd: assert property (@(posedge ref_clk) disable iff (srst)
        rsp.valid |-> rsp.rdata[63:2] == '0)
        else $error("reserved read bits not zero");

    a_fault_rdata: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && fault |=> rsp.rdata == 64'h0000_0000_0000_0000)
        else $error("faulted access returned data");

    a_write_rdata: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write |=> rsp.rdata == 64'h0000_0000_0000_0000)
        else $error("write returned data");

    a_enable_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !(req.valid && req.write) |=> $stable(feat_reg))
        else $error("enables changed without a write");

    a_good_write: assert property (@(posedge ref_clk) disable iff (srst)
        req.valid && req.write && hit && reg_present
        && (req.wdata & iqe_pkg::FEAT_RSVD_MASK) == 64'h0000_0000_0000_0000
        && (!req.wdata[iqe_pkg::BIT_MON_EN] || mon_ok)
        && (!req.wdata[iqe_pkg::BIT_ALLOC_EN] || alloc_ok)
        |=> rsp.valid && !rsp.fault)
        else $error("legal write faulted");

    // configuration gate checks
    a_cfg_gate: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && !cfg_is_alloc && !monitor_active |=> !cfg_accept)
        else $error("config accepted while monitoring disabled");

    a_tag_limit: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && cfg_is_alloc && {1'b0, cfg_tag} >= CLASS_LIM |=> !cfg_accept)
        else $error("service class tag over limit accepted");

    a_alloc_gate: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && cfg_is_alloc && !alloc_active |=> !cfg_accept)
        else $error("config accepted while allocation disabled");

    a_mon_tag_limit: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && !cfg_is_alloc && {1'b0, cfg_tag} >= MON_LIM |=> !cfg_accept)
        else $error("monitor tag over limit accepted");

    a_alloc_pass: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && cfg_is_alloc && alloc_active && {1'b0, cfg_tag} < CLASS_LIM
        |=> cfg_accept)
        else $error("legal allocation config dropped");

    a_mon_pass: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && !cfg_is_alloc && monitor_active && {1'b0, cfg_tag} < MON_LIM
        |=> cfg_accept)
        else $error("legal monitor config dropped");

    a_both_off: assert property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && !alloc_active && !monitor_active |=> !cfg_accept)
        else $error("config accepted with both classes disabled");

    a_cfg_quiet: assert property (@(posedge ref_clk) disable iff (srst)
        !cfg_valid |=> !cfg_accept)
        else $error("config accepted without attempt");

    // scenario covers
    c_enable_both: cover property (@(posedge ref_clk) disable iff (srst)
        alloc_active && monitor_active);
    c_fault_seen: cover property (@(posedge ref_clk) disable iff (srst)
        rsp.valid && rsp.fault);
    c_cfg_taken: cover property (@(posedge ref_clk) disable iff (srst)
        cfg_accept);
    c_tag_refused: cover property (@(posedge ref_clk) disable iff (srst)
        cfg_valid && cfg_is_alloc && alloc_active && {1'b0, cfg_tag} >= CLASS_LIM);
    c_read_enabled: cover property (@(posedge ref_clk) disable iff (srst)
        rsp.valid && !rsp.fault && rsp.rdata[1:0] == 2'b11);

endmodule

// ### test/testbench.sv
// self-checking bench for the io agent feature-enable block and its query decode
// assumes iqe_pkg is compiled first; all inputs change on the falling ref_clk edge
`timescale 1ns/10ps
module testbench;
    localparam int        MON_LIM = 256;
    localparam int        CLASS_LIM = 16;
    logic                 ref_clk;
    logic                 srst;
    iqe_pkg::iqe_caps_s   caps;
    iqe_pkg::iqe_req_s    req;
    iqe_pkg::iqe_rsp_s    rsp;
    logic                 id_valid;
    logic [31:0]          id_leaf;
    logic [31:0]          id_subleaf;
    iqe_pkg::iqe_id_rsp_s id_rsp;
    logic                 cfg_valid;
    logic                 cfg_is_alloc;
    logic [15:0]          cfg_tag;
    logic                 cfg_accept;
    logic                 alloc_active;
    logic                 monitor_active;
    int                   bad_count;
    int                   checks_done;
    logic [1:0]           feat_model;
    logic [31:0]          leaves [3];
    logic [15:0]          tags [5];
    logic [63:0]          wdata;
    int                   wsel;
    logic [64:0]          exp_q [$];

    iqe_feature_enable #(.MON_TAG_MAX(MON_LIM), .CLASS_TAG_MAX(CLASS_LIM)) i_dut
    (
        .ref_clk        (ref_clk),
        .srst           (srst),
        .caps           (caps),
        .req            (req),
        .rsp            (rsp),
        .id_valid       (id_valid),
        .id_leaf        (id_leaf),
        .id_subleaf     (id_subleaf),
        .id_rsp         (id_rsp),
        .cfg_valid      (cfg_valid),
        .cfg_is_alloc   (cfg_is_alloc),
        .cfg_tag        (cfg_tag),
        .cfg_accept     (cfg_accept),
        .alloc_active   (alloc_active),
        .monitor_active (monitor_active)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one quiet cycle between requests so no strobe is lowered and raised at once
    task automatic idle();
        req.valid = 1'b0;
        id_valid = 1'b0;
        cfg_valid = 1'b0;
        @(negedge ref_clk);
        check({rsp.valid, id_rsp.valid, cfg_accept}, 64'h0000_0000_0000_0000);
    endtask

    task automatic reg_op(input logic wr, input logic [31:0] addr, input logic [63:0] wd);
        logic mon_ok;
        logic alloc_ok;
        logic flt;
        logic [64:0] exp_rsp;
        mon_ok = (caps.io_occ_mon & caps.occ_mon) | (caps.io_bw_mon & caps.bw_mon);
        alloc_ok = caps.io_alloc & caps.alloc;
        flt = (addr != iqe_pkg::FEAT_ADDR) || !(caps.io_occ_mon | caps.io_bw_mon | caps.io_alloc)
            || (wr && ((wd & iqe_pkg::FEAT_RSVD_MASK) != 0 || (wd[1] && !mon_ok)
            || (wd[0] && !alloc_ok)));
        exp_q.push_back({flt, (wr || flt) ? 64'h0000_0000_0000_0000 : {62'h0, feat_model}});
        req = {1'b1, wr, addr, wd};
        @(negedge ref_clk);
        if (wr && !flt)
            feat_model = wd[1:0];
        exp_rsp = exp_q.pop_front();
        check(rsp.valid, 1'b1);
        check(rsp.fault, exp_rsp[64]);
        check(rsp.rdata, exp_rsp[63:0]);
        check(alloc_active, feat_model[0]);
        check(monitor_active, feat_model[1]);
        idle();
    endtask

    task automatic id_op(input logic [31:0] leaf, input logic [31:0] sub);
        logic [31:0] exp_a;
        logic [31:0] exp_c;
        exp_a = '0;
        exp_c = '0;
        if (leaf == iqe_pkg::LEAF_MONITOR && sub == iqe_pkg::SUBLEAF_L3)
            exp_a = {21'h0, caps.io_bw_mon, caps.io_occ_mon, 9'h0};
        if (leaf == iqe_pkg::LEAF_ALLOC && sub == iqe_pkg::SUBLEAF_L3)
            exp_c = {29'h0, caps.code_data_split_priority, caps.io_alloc, 1'b0};
        id_valid = 1'b1;
        id_leaf = leaf;
        id_subleaf = sub;
        @(negedge ref_clk);
        check(id_rsp.valid, 1'b1);
        check(id_rsp.res_a, exp_a);
        check(id_rsp.res_c, exp_c);
        idle();
    endtask

    task automatic cfg_op(input logic is_alloc, input logic [15:0] tag);
        logic acc;
        acc = is_alloc ? (feat_model[0] && tag < CLASS_LIM) : (feat_model[1] && tag < MON_LIM);
        cfg_valid = 1'b1;
        cfg_is_alloc = is_alloc;
        cfg_tag = tag;
        @(negedge ref_clk);
        check(cfg_accept, acc);
        idle();
    endtask

    initial
    begin
        ref_clk = 1'b0;
        srst = 1'b1;
        caps = '0;
        req = '0;
        id_valid = 1'b0;
        id_leaf = '0;
        id_subleaf = '0;
        cfg_valid = 1'b0;
        cfg_is_alloc = 1'b0;
        cfg_tag = '0;
        bad_count = 0;
        checks_done = 0;
        feat_model = 2'b00;
        leaves = '{iqe_pkg::LEAF_MONITOR, iqe_pkg::LEAF_ALLOC, 32'h0000_0007};
        tags = '{16'h0000, 16'h000f, 16'h0010, 16'h00ff, 16'h0100};
        void'($urandom(21716));
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        caps = 7'h7f;
        reg_op(1'b0, iqe_pkg::FEAT_ADDR, '0);
        repeat (300)
        begin
            caps = 7'($urandom);
            for (int i = 0; i < 3; i++)
                for (int j = 0; j < 3; j++)
                    id_op(leaves[i], 32'(j));
            wsel = $urandom_range(0, 5);
            wdata = (wsel < 4) ? 64'(wsel) : (wsel == 4) ? 64'h0000_0000_0000_0004
                                                          : 64'h8000_0000_0000_0002;
            reg_op(1'b1, iqe_pkg::FEAT_ADDR, wdata);
            reg_op(1'b0, ($urandom_range(0, 7) == 0) ? 32'h0000_0c84 : iqe_pkg::FEAT_ADDR, '0);
            cfg_op(1'($urandom), tags[$urandom_range(0, 4)]);
            cfg_op(1'($urandom), 16'($urandom));
        end
        // reset in mid-run must drop both enables
        caps = 7'h7f;
        reg_op(1'b1, iqe_pkg::FEAT_ADDR, 64'h0000_0000_0000_0003);
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check({alloc_active, monitor_active}, 64'h0000_0000_0000_0000);
        srst = 1'b0;
        feat_model = 2'b00;
        reg_op(1'b0, iqe_pkg::FEAT_ADDR, '0);
        end_sim();
    end

    // full run is about 8000 cycles; give up at 20000
    initial
    begin
        #200_000;
        bad_count++;
        end_sim();
    end
endmodule
